// [hdl/wdo_watchdog_options.sv]
// Summary of operation
// [RULE1] each option latch takes one write after reset; reads allowed anytime
// [RULE2] any reset clears every option bit except the voltage-mode bit
// [RULE3] voltage-mode bit cleared and re-armed for one write only by power-on reset
// [RULE4] oscillator keep-alive bit keeps clocks running in stop mode
// [RULE5] serial clock select: 1 bus clock, 0 oscillator clock
// [RULE6] watchdog period select: 1 gives 8176 cycles, 0 gives 262128 cycles
// [RULE7] monitor stop-enable keeps monitor running in stop while powered
// [RULE8] monitor reset-disable blocks the monitor reset request
// [RULE9] monitor power-disable powers the monitor down
// [RULE10] voltage-mode bit selects 5 V trip points when 1, 3 V when 0
// [RULE11] short-recovery bit gives 32 cycle stop exit, else 4096
// [RULE12] stop exit through monitor reset always uses the long delay
// [RULE13] stop instruction with stop disabled is illegal and resets
// [RULE14] watchdog disable bit turns the watchdog off completely
// [RULE15] 6-bit counter behind 12-bit prescaler, overflow raises reset
// [RULE16] any write to service location clears counter and prescaler stages 12-5
// [RULE17] service location reads back the reset vector low byte
// [RULE18] overflow drives reset low 32 cycles and flags watchdog cause
// [RULE19] stop mode gates the watchdog clock and clears the prescaler
// [RULE20] prescaler cleared 4096 cycles after power-up; internal reset clears all
// [RULE21] test voltage or blank-vector monitor entry disables the watchdog
// [RULE22] watchdog keeps counting in wait mode
// [RULE23] later writes to a written option latch are ignored
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "wdo_params.svh"

module wdo_watchdog_options
   import wdo_pkg::*;
#(
   parameter logic [17:0] LONG_PERIOD = `WDO_LONG_PERIOD
) (
   // clock and power-on reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // axi4-lite write
   input  wire logic [31:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // axi4-lite read
   input  wire logic [31:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // cpu and system events
   input  wire logic        stopInstr,
   input  wire logic        wakeEvent,
   input  wire logic        otherResetReq,
   input  wire logic        lowvoltResetReq,
   // monitor and break conditions
   input  wire logic        monitorMode,
   input  wire logic        breakState,
   input  wire logic        testVoltOnRst,
   input  wire logic        testVoltOnIrq,
   input  wire logic        blankVectorEntry,
   // reset pin, open drain
   input  wire logic        rstPinIn,
   output logic             rstPinOut,
   output logic             rstPinOeN,
   // system controls
   output logic             systemReset,
   output logic             watchdogCauseSet,
   output logic             cpuClockRun,
   output logic             oscRunEnable,
   output logic             serialClockSel,
   output logic             lowvoltPowerOn,
   output logic             lowvoltRunEnable,
   output logic             lowvoltVoltageMode
);

   logic [31:0] awAddr_q;
   logic        awHeld_q;
   logic [7:0]  wData_q;
   logic        wStrb0_q;
   logic        wHeld_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;

   logic [7:0]  opt1_q;
   logic [7:0]  opt2_q;
   logic        opt1Done_q;
   logic        opt2Done_q;
   logic        vm_q;
   logic        vmDone_q;
   logic        blank_q;

   logic [11:0] pre_q;
   logic [5:0]  cnt_q;
   logic [12:0] porCnt_q;
   logic        porDone_q;
   logic [5:0]  rstCnt_q;
   logic        wdCause_q;
   logic [12:0] recCnt_q;
   wdo_state_t  st_q;

   logic        doWrite;
   wdo_index_t  awIdx;
   wdo_index_t  arIdx;
   logic        awOk;
   logic        arOk;
   logic        wrOpt1;
   logic        wrOpt2;
   logic        wrService;
   logic        wrMapped;
   logic [31:0] rdNext;
   logic        rdErr;

   logic        rstActive;
   logic        resetEvent;
   logic        clearAll;
   logic        lowvoltRst;
   logic        illegalStop;
   logic        enterStop;
   logic        wdBlocked;
   logic        wdEnabled;
   logic        wdOverflow;
   logic        porClear;
   logic [17:0] elapsed;
   logic [17:0] period;

   // ---------------- bus slave ----------------
   assign awready = !awHeld_q && !bvalid_q;
   assign wready  = !wHeld_q && !bvalid_q;
   assign doWrite = awHeld_q && wHeld_q && !bvalid_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign arready = !rvalid_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;

   assign awIdx = awAddr_q[17:2];
   assign arIdx = araddr[17:2];
   assign awOk  = (awAddr_q[31:18] == 14'h0000) && (awAddr_q[1:0] == 2'h0);
   assign arOk  = (araddr[31:18] == 14'h0000) && (araddr[1:0] == 2'h0);

   assign wrOpt1    = doWrite && awOk && (awIdx == `WDO_IDX_OPT1);
   assign wrOpt2    = doWrite && awOk && (awIdx == `WDO_IDX_OPT2);
   assign wrService = doWrite && awOk && (awIdx == `WDO_IDX_SERVICE);
   assign wrMapped  = wrOpt1 || wrOpt2 || wrService ||
                      (doWrite && awOk && (awIdx == `WDO_IDX_STATUS));

   // address and data may arrive in either order
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         awHeld_q <= 1'b0;
         awAddr_q <= 32'h0000_0000;
      end else if (awvalid && awready) begin
         awHeld_q <= 1'b1;
         awAddr_q <= awaddr;
      end else if (doWrite) begin
         awHeld_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wHeld_q  <= 1'b0;
         wData_q  <= 8'h00;
         wStrb0_q <= 1'b0;
      end else if (wvalid && wready) begin
         wHeld_q  <= 1'b1;
         wData_q  <= wdata[7:0];
         wStrb0_q <= wstrb[0];
      end else if (doWrite) begin
         wHeld_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `WDO_RESP_OKAY;
      end else if (doWrite) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wrMapped ? `WDO_RESP_OKAY : `WDO_RESP_SLVERR;
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // reads never disturb any state
   always_comb begin
      rdNext = 32'h0000_0000;
      rdErr  = 1'b0;
      if (!arOk) begin
         rdErr = 1'b1;
      end else begin
         case (arIdx)
            `WDO_IDX_OPT1: begin
               rdNext[7:0]           = opt1_q; // [RULE1]
               rdNext[`WDO_B1_VMODE] = vm_q;
            end
            `WDO_IDX_OPT2: begin
               rdNext[7:0] = opt2_q; // [RULE1]
            end
            `WDO_IDX_SERVICE: begin
               rdNext[7:0] = `WDO_VECTOR_LOW; // [RULE17]
            end
            `WDO_IDX_STATUS: begin
               rdNext[`WDO_BS_STATE +: 3]  = st_q;
               rdNext[`WDO_BS_OPT2_DONE]   = opt2Done_q;
               rdNext[`WDO_BS_OPT1_DONE]   = opt1Done_q;
               rdNext[`WDO_BS_VM_DONE]     = vmDone_q;
               rdNext[`WDO_BS_WD_BLOCK]    = wdBlocked;
               rdNext[`WDO_BS_RST_ACT]     = rstActive;
            end
            default: begin
               rdErr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= `WDO_RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rdNext;
         rresp_q  <= rdErr ? `WDO_RESP_SLVERR : `WDO_RESP_OKAY;
      end else if (rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ---------------- reset sequencing ----------------
   assign rstActive   = (rstCnt_q != 6'h00);
   assign lowvoltRst  = lowvoltResetReq && !opt1_q[`WDO_B1_LV_RSTD]; // [RULE8]
   assign illegalStop = stopInstr && (st_q == WDO_RUN) && !rstActive &&
                        !opt1_q[`WDO_B1_STOP_EN]; // [RULE13]
   assign enterStop   = stopInstr && (st_q == WDO_RUN) && !rstActive &&
                        opt1_q[`WDO_B1_STOP_EN];
   // pin sensed low only counts when it is not our own drive
   assign resetEvent  = wdOverflow || illegalStop || lowvoltRst || otherResetReq ||
                        (!rstPinIn && !rstActive);
   assign clearAll    = resetEvent || rstActive;

   // every internal source stretches to a fixed pin pulse
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rstCnt_q <= 6'h00;
      end else if (resetEvent) begin
         rstCnt_q <= `WDO_RST_PULSE; // [RULE18]
      end else if (rstActive) begin
         rstCnt_q <= rstCnt_q - 6'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wdCause_q <= 1'b0;
      end else begin
         wdCause_q <= wdOverflow; // [RULE18]
      end
   end

   assign rstPinOut        = 1'b0;
   assign rstPinOeN        = !rstActive;
   assign systemReset      = reset || rstActive;
   assign watchdogCauseSet = wdCause_q;

   // ---------------- option latches ----------------
   always_ff @(posedge sys_clk) begin
      if (reset || clearAll) begin
         opt1_q     <= `WDO_OPT_RESET; // [RULE2]
         opt1Done_q <= 1'b0;
      end else if (wrOpt1 && wStrb0_q && !opt1Done_q) begin
         opt1_q                <= wData_q; // [RULE1]
         opt1_q[`WDO_B1_VMODE] <= 1'b0;
         opt1Done_q            <= 1'b1; // [RULE23]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset || clearAll) begin
         opt2_q     <= `WDO_OPT_RESET; // [RULE2]
         opt2Done_q <= 1'b0;
      end else if (wrOpt2 && wStrb0_q && !opt2Done_q) begin
         opt2_q     <= wData_q; // [RULE1]
         opt2Done_q <= 1'b1; // [RULE23]
      end
   end

   // voltage mode survives internal resets, so a mis-set value sticks until power-up
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         vm_q     <= 1'b0; // [RULE3]
         vmDone_q <= 1'b0;
      end else if (wrOpt1 && wStrb0_q && !vmDone_q && !clearAll) begin
         vm_q     <= wData_q[`WDO_B1_VMODE]; // [RULE3]
         vmDone_q <= 1'b1;
      end
   end

   // ---------------- watchdog ----------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         blank_q <= 1'b0;
      end else if (blankVectorEntry && !testVoltOnIrq) begin
         blank_q <= 1'b1; // [RULE21]
      end
   end

   assign wdBlocked = (monitorMode && (testVoltOnRst || testVoltOnIrq)) ||
                      (breakState && testVoltOnRst) || blank_q; // [RULE21]
   // wait mode has no term here, so counting carries on while waiting
   assign wdEnabled = !opt1_q[`WDO_B1_WD_DIS] && !wdBlocked && porDone_q &&
                      (st_q != WDO_STOP) && !rstActive; // [RULE14] [RULE19] [RULE22]
   assign period    = opt1_q[`WDO_B1_WD_PERIOD] ? `WDO_SHORT_PERIOD : LONG_PERIOD; // [RULE6]
   assign elapsed   = {cnt_q, pre_q};
   assign wdOverflow = wdEnabled && (elapsed == period - 18'h0_0001); // [RULE15]
   assign porClear  = !porDone_q && (porCnt_q == `WDO_POR_DELAY - 13'h0001);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         porCnt_q  <= 13'h0000;
         porDone_q <= 1'b0;
      end else if (!porDone_q) begin
         porCnt_q  <= porCnt_q + 13'h0001;
         porDone_q <= porClear;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset || clearAll) begin
         pre_q <= 12'h000; // [RULE20]
         cnt_q <= 6'h00;
      end else if (enterStop || porClear) begin
         pre_q <= 12'h000; // [RULE19] [RULE20]
      end else if (wrService) begin
         cnt_q      <= 6'h00; // [RULE16]
         pre_q[11:4] <= 8'h00;
      end else if (wdEnabled) begin
         {cnt_q, pre_q} <= elapsed + 18'h0_0001; // [RULE15]
      end
   end

   // ---------------- stop mode and recovery ----------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_q     <= WDO_RUN;
         recCnt_q <= 13'h0000;
      end else if (resetEvent) begin
         // a monitor reset while stopped still pays the long recovery
         st_q     <= (st_q == WDO_STOP && lowvoltRst) ? WDO_RECOVER : WDO_RUN; // [RULE12]
         recCnt_q <= `WDO_REC_LONG; // [RULE12]
      end else begin
         case (st_q)
            WDO_RUN: begin
               if (enterStop) begin
                  st_q <= WDO_STOP;
               end
            end
            WDO_STOP: begin
               if (wakeEvent) begin
                  st_q     <= WDO_RECOVER;
                  recCnt_q <= opt1_q[`WDO_B1_SHORT_REC] ?
                              `WDO_REC_SHORT : `WDO_REC_LONG; // [RULE11]
               end
            end
            WDO_RECOVER: begin
               if (recCnt_q == 13'h0001) begin
                  st_q <= WDO_RUN;
               end
               recCnt_q <= recCnt_q - 13'h0001;
            end
            default: begin
               st_q <= WDO_RUN;
            end
         endcase
      end
   end

   assign cpuClockRun        = (st_q == WDO_RUN) && !rstActive;
   assign oscRunEnable       = (st_q != WDO_STOP) || opt2_q[`WDO_B2_OSC_KEEP]; // [RULE4]
   assign serialClockSel     = opt2_q[`WDO_B2_SER_CLK]; // [RULE5]
   assign lowvoltPowerOn     = !opt1_q[`WDO_B1_LV_PWRD]; // [RULE9]
   assign lowvoltRunEnable   = !opt1_q[`WDO_B1_LV_PWRD] &&
                               ((st_q != WDO_STOP) || opt1_q[`WDO_B1_LV_STOP]); // [RULE7]
   assign lowvoltVoltageMode = vm_q; // [RULE10]

   // ---------------- checks ----------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   a_opt_write_once: assert property ( // [RULE23]
      opt1Done_q && !clearAll |=> opt1_q == $past(opt1_q))
      else $error("written option latch changed");

   a_opt_reset_clear: assert property ( // [RULE2]
      resetEvent |=> (opt1_q == 8'h00) && (opt2_q == 8'h00) && !opt1Done_q)
      else $error("option latches not cleared by reset");

   a_vmode_keep: assert property ( // [RULE3]
      resetEvent |=> vm_q == $past(vm_q))
      else $error("voltage mode changed by internal reset");

   a_wd_pin_pulse: assert property ( // [RULE18]
      wdOverflow |=> (!rstPinOeN)[*8] ##24 !rstPinOeN)
      else $error("watchdog reset pulse too short");

   a_wd_cause_flag: assert property ( // [RULE18]
      wdOverflow |=> watchdogCauseSet ##1 !watchdogCauseSet)
      else $error("watchdog cause flag not pulsed");

   a_service_clear: assert property ( // [RULE16]
      wrService && !clearAll && !enterStop && !porClear |=>
         (cnt_q == 6'h00) && (pre_q[11:4] == 8'h00))
      else $error("service write did not clear watchdog");

   a_illegal_stop: assert property ( // [RULE13]
      illegalStop |=> rstActive && (st_q == WDO_RUN))
      else $error("illegal stop did not reset");

   a_stop_gate: assert property ( // [RULE19]
      enterStop && !resetEvent |=> (st_q == WDO_STOP) && (pre_q == 12'h000) && !wdEnabled)
      else $error("stop did not gate watchdog");

   a_recover_short: assert property (disable iff (reset || resetEvent) // [RULE11]
      (st_q == WDO_STOP) && wakeEvent && opt1_q[`WDO_B1_SHORT_REC] |->
         ##32 !cpuClockRun ##1 cpuClockRun)
      else $error("short stop recovery length wrong");

   a_wd_disabled: assert property ( // [RULE14]
      opt1_q[`WDO_B1_WD_DIS] || blank_q |-> !wdOverflow)
      else $error("disabled watchdog overflowed");

   c_wd_overflow: cover property (wdOverflow);
   c_stop_recover: cover property ((st_q == WDO_RECOVER) ##1 (st_q == WDO_RUN));
   c_opt_write: cover property (wrOpt1 && !opt1Done_q ##1 opt1Done_q);
   c_illegal_stop: cover property (illegalStop);

endmodule

// [shared/wdo_params.svh]
`ifndef WDO_PARAMS_SVH
`define WDO_PARAMS_SVH

// register indices, byte address is four times the index
`define WDO_IDX_OPT2       16'h001e
`define WDO_IDX_OPT1       16'h001f
`define WDO_IDX_SERVICE    16'hffff
`define WDO_IDX_STATUS     16'h0020

// option latch two fields
`define WDO_B2_OSC_KEEP    0
`define WDO_B2_SER_CLK     1

// option latch one fields
`define WDO_B1_WD_DIS      0
`define WDO_B1_STOP_EN     1
`define WDO_B1_SHORT_REC   2
`define WDO_B1_VMODE       3
`define WDO_B1_LV_PWRD     4
`define WDO_B1_LV_RSTD     5
`define WDO_B1_LV_STOP     6
`define WDO_B1_WD_PERIOD   7

// status fields
`define WDO_BS_STATE       0
`define WDO_BS_OPT2_DONE   3
`define WDO_BS_OPT1_DONE   4
`define WDO_BS_VM_DONE     5
`define WDO_BS_WD_BLOCK    6
`define WDO_BS_RST_ACT     7

// reset values and fixed read values
`define WDO_OPT_RESET      8'h00
`define WDO_VECTOR_LOW     8'h00

// timing counts in oscillator cycles
`define WDO_LONG_PERIOD    18'h3_fff0
`define WDO_SHORT_PERIOD   18'h0_1ff0
`define WDO_REC_SHORT      13'h0020
`define WDO_REC_LONG       13'h1000
`define WDO_POR_DELAY      13'h1000
`define WDO_RST_PULSE      6'h20

// bus answers
`define WDO_RESP_OKAY      2'h0
`define WDO_RESP_SLVERR    2'h2

`endif

// [shared/wdo_pkg.sv]
package wdo_pkg;

   typedef enum logic [2:0] {
      WDO_RUN     = 3'h1,
      WDO_STOP    = 3'h2,
      WDO_RECOVER = 3'h4
   } wdo_state_t;

   typedef logic [15:0] wdo_index_t;

endpackage

// [tb/wdo_watchdog_options_tb.sv]
`timescale 1ns/1ps
`include "wdo_params.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin nMismatch++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, e); end end

module wdo_watchdog_options_tb;
   import wdo_pkg::*;
   // short long-period keeps the run brief
   localparam logic [17:0] LP = 18'h0_0200;
   logic        sys_clk, reset, awvalid, wvalid, bready, arvalid, rready;
   logic [31:0] awaddr, wdata, araddr;
   logic [3:0]  wstrb;
   logic        stopInstr, wakeEvent, otherResetReq, lowvoltResetReq;
   logic        monitorMode, breakState, testVoltOnRst, testVoltOnIrq, blankVectorEntry;
   wire         awready, wready, bvalid, arready, rvalid, rstPinOut, rstPinOeN;
   wire         systemReset, watchdogCauseSet, cpuClockRun, oscRunEnable, serialClockSel;
   wire         lowvoltPowerOn, lowvoltRunEnable, lowvoltVoltageMode;
   wire [1:0]   bresp, rresp;
   wire [31:0]  rdata;
   // open-drain pin with pull-up
   wire         rstPinIn = rstPinOeN ? 1'b1 : rstPinOut;
   logic [7:0]  o1M, o2M, v, rv;
   logic [1:0]  r;
   bit          d1, d2, vmD;
   logic        cause;
   int          checks, nMismatch, cyc, n, dly, len;

   wdo_watchdog_options #(.LONG_PERIOD(LP)) dut (
      .sys_clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .stopInstr, .wakeEvent, .otherResetReq, .lowvoltResetReq, .monitorMode,
      .breakState, .testVoltOnRst, .testVoltOnIrq, .blankVectorEntry, .rstPinIn,
      .rstPinOut, .rstPinOeN, .systemReset, .watchdogCauseSet, .cpuClockRun,
      .oscRunEnable, .serialClockSel, .lowvoltPowerOn, .lowvoltRunEnable,
      .lowvoltVoltageMode);

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   always @(negedge sys_clk) begin
      if (watchdogCauseSet === 1'b1) cause <= 1'b1;
   end

   // hang guard, the planned sequence needs about 21k cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 60000) begin
         nMismatch++;
         tally_and_finish();
      end
   end

   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic ta, tw, bv;
      awaddr <= {14'h0000, idx, 2'h0};
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // values seen at the falling edge are the ones the next rising edge takes
      do begin
         @(negedge sys_clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         bv = bvalid;
         r = bresp;
         @(posedge sys_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (!bv);
      bready <= 1'b0;
      @(posedge sys_clk);
      // the latch keeps only the first write; voltage mode only once per power-up
      if (idx == `WDO_IDX_OPT2 && !d2 && wstrb[0]) begin
         o2M = d;
         d2 = 1;
      end
      if (idx == `WDO_IDX_OPT1 && !d1 && wstrb[0]) begin
         o1M = vmD ? {d[7:4], o1M[3], d[2:0]} : d;
         d1 = 1;
         vmD = 1;
      end
   endtask

   task automatic rd(input logic [15:0] idx);
      logic        ta, rv2;
      logic [23:0] rh;
      araddr <= {14'h0000, idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge sys_clk);
         ta = arvalid && arready;
         rv2 = rvalid;
         rv = rdata[7:0];
         rh = rdata[31:8];
         r = rresp;
         @(posedge sys_clk);
         if (ta) arvalid <= 1'b0;
      end while (!rv2);
      rready <= 1'b0;
      @(posedge sys_clk);
      `CHK(rh, 24'h00_0000)
   endtask

   // 0 stop instruction, 1 wake, 2 monitor reset request
   task automatic pulse(input int s);
      if (s == 0) stopInstr <= 1'b1;
      if (s == 1) wakeEvent <= 1'b1;
      if (s == 2) lowvoltResetReq <= 1'b1;
      @(posedge sys_clk);
      {stopInstr, wakeEvent, lowvoltResetReq} <= 3'h0;
   endtask

   // counts cycles from the wake or reset edge until the cpu clock runs again
   task automatic wrun();
      n = 0;
      while (n < 5000) begin
         @(negedge sys_clk);
         if (cpuClockRun === 1'b1) break;
         @(posedge sys_clk);
         n++;
      end
      @(posedge sys_clk);
   endtask

   // waits for the reset pin to be pulled, then measures how long it stays low
   task automatic wp(input int lim);
      cause = 1'b0;
      dly = 0;
      len = 0;
      while (dly < lim) begin
         @(negedge sys_clk);
         if (rstPinOeN === 1'b0) break;
         dly++;
      end
      while (rstPinOeN === 1'b0 && len < 100) begin
         `CHK(systemReset, 1'b1)
         `CHK(rstPinOut, 1'b0)
         @(negedge sys_clk);
         len++;
      end
      @(posedge sys_clk);
   endtask

   task automatic irst();
      o1M = o1M & 8'h08;
      o2M = 8'h00;
      d1 = 0;
      d2 = 0;
   endtask

   task automatic por();
      reset <= 1'b1;
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      irst();
      o1M = 8'h00;
      vmD = 0;
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, nMismatch);
      if (nMismatch == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      {reset, awvalid, wvalid, bready, arvalid, rready, stopInstr, wakeEvent} = 8'h80;
      {otherResetReq, lowvoltResetReq, monitorMode, breakState} = 4'h0;
      {testVoltOnRst, testVoltOnIrq, blankVectorEntry} = 3'h0;
      {awaddr, wdata, araddr} = 96'h0;
      wstrb = 4'hf;
      void'($urandom(32'hde8af4d2));
      por();
      rd(`WDO_IDX_OPT1);
      `CHK(rv, o1M)
      rd(`WDO_IDX_SERVICE);
      `CHK(rv, `WDO_VECTOR_LOW)
      rd(16'h0021);
      `CHK(r, `WDO_RESP_SLVERR)
      wr(16'h0021, 8'h00);
      `CHK(r, `WDO_RESP_SLVERR)
      v = 8'($urandom);
      // a write without its low byte lane must not use up the one write
      wstrb <= 4'he;
      wr(`WDO_IDX_OPT2, ~v);
      `CHK(r, `WDO_RESP_OKAY)
      wstrb <= 4'hf;
      wr(`WDO_IDX_OPT2, v);
      wr(`WDO_IDX_OPT2, ~v);
      rd(`WDO_IDX_OPT2);
      `CHK(rv, o2M)
      `CHK(serialClockSel, v[1])
      wr(`WDO_IDX_OPT1, 8'h4a);
      rd(`WDO_IDX_OPT1);
      `CHK(rv, o1M)
      rd(`WDO_IDX_STATUS);
      `CHK(rv, 8'h39)
      `CHK(lowvoltVoltageMode, 1'b1)
      `CHK(lowvoltPowerOn, 1'b1)
      $display("test options done");
      pulse(0);
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK(cpuClockRun, 1'b0)
      `CHK(oscRunEnable, v[0])
      `CHK(lowvoltRunEnable, 1'b1)
      @(posedge sys_clk);
      pulse(1);
      wrun();
      `CHK(n, 4096)
      $display("test stop done");
      wr(`WDO_IDX_SERVICE, 8'($urandom));
      wp(LP + 40);
      `CHK(dly >= LP - 24 && dly <= LP + 8, 1'b1)
      `CHK(len, 32)
      `CHK(cause, 1'b1)
      irst();
      rd(`WDO_IDX_OPT1);
      `CHK(rv, o1M)
      wr(`WDO_IDX_OPT1, 8'h31);
      rd(`WDO_IDX_OPT1);
      `CHK(rv, o1M)
      `CHK(lowvoltPowerOn, 1'b0)
      pulse(2);
      wp(1500);
      `CHK(len, 0)
      pulse(0);
      wp(40);
      `CHK(len, 32)
      irst();
      pulse(2);
      wp(40);
      `CHK(len, 32)
      irst();
      $display("test resets done");
      breakState <= 1'b1;
      testVoltOnRst <= 1'b1;
      wr(`WDO_IDX_SERVICE, 8'h00);
      wp(1500);
      `CHK(len, 0)
      breakState <= 1'b0;
      testVoltOnRst <= 1'b0;
      wr(`WDO_IDX_SERVICE, 8'h00);
      wp(LP + 40);
      `CHK(len, 32)
      $display("test break done");
      por();
      rd(`WDO_IDX_OPT1);
      `CHK(rv, 8'h00)
      // short recovery, then a monitor reset out of stop, which takes the long one
      wr(`WDO_IDX_OPT1, 8'h86);
      pulse(0);
      repeat (2) @(posedge sys_clk);
      pulse(1);
      wrun();
      `CHK(n, 32)
      pulse(0);
      repeat (2) @(posedge sys_clk);
      pulse(2);
      wrun();
      `CHK(n, 4096)
      irst();
      $display("test recovery done");
      // the long recovery has outlasted the power-up prescaler delay
      wr(`WDO_IDX_OPT1, 8'h80);
      wr(`WDO_IDX_SERVICE, 8'h00);
      wp(8300);
      `CHK(dly >= 8152 && dly <= 8184, 1'b1)
      $display("test short period done");
      tally_and_finish();
   end
endmodule
